/* rtl/supervisor_consts.vh */
`ifndef SUPERVISOR_CONSTS_VH
`define SUPERVISOR_CONSTS_VH

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_DELAY      8'h04
`define REG_DISC       8'h08
`define REG_RECONN     8'h0c
`define REG_GENSTART   8'h10
`define REG_ABSMAX     8'h14
`define REG_BOOSTMAX   8'h18
`define REG_ILIMIT     8'h1c
`define REG_SITE       8'h20
`define REG_STATUS     8'h24

// Control fields
`define CTRL_TESTA     0
`define CTRL_FAIL      1

// Reset values, voltages in 10 mV, currents in 10 mA
`define RST_DELAY      8'h0a
`define RST_DISC       16'h046a
`define RST_RECONN     16'h0514
`define RST_GENSTART   16'h0488
`define RST_ABSMAX     16'h05dc
`define RST_BOOSTMAX   16'h05a0
`define RST_ILIMIT     16'h1388
`define RST_SITE       8'h01

// Delay limits in seconds
`define DELAY_MIN      8'h01
`define DELAY_MAX      8'hfa

// Fixed offsets and levels, 10 mV / 10 mA units
`define V_TENTH        17'h0000a
`define V_HIDISC       17'h00014
`define V_LOADDROP     17'h00032
`define V_LOADLOWBAT   16'h04e2
`define V_LOADOFF      16'h0320
`define I_STUCK        16'h0258
`define I_OPENTEST     16'h04b0
`define I_BANKMIN      16'h004b

// Times
`define TENTHS_PER_SEC 12'h00a
`define OC_TENTHS      12'h003
`define TESTA_TENTHS   12'h014
`define BANK_PERIOD    14'h2328
`define SETTLE_TENTHS  4'ha
`define CLK_HZ         200000000
`define TENTH_NS       100000000
`define CLK_NS         5
`define BAUD           9600

// Serial query codes
`define QRY_INPUTS     8'h00

`endif

/* rtl/battery_load_alarm_supervisor.v */
`timescale 1ns/1ps
`include "supervisor_consts.vh"

module battery_load_alarm_supervisor #(
   parameter TENTH_CYCLES = (`TENTH_NS + `CLK_NS - 1) / `CLK_NS,
   parameter BAUD_DIV     = `CLK_HZ / `BAUD,
   parameter NBANK        = 4
) (
   // Clock and reset
   input  wire              clk,
   input  wire              rst,
   // APB slave
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output wire              pready,
   output reg  [31:0]       prdata,
   output wire              pslverr,
   // Filtered measurements
   input  wire [15:0]       batVolt,
   input  wire [15:0]       loadVolt,
   input  wire [15:0]       loadCur,
   input  wire [15:0]       chargeCur,
   // Bank switches
   input  wire [NBANK-1:0]  bankReq,
   output reg  [NBANK-1:0]  bankOn,
   // Alarm contact inputs, high when open
   input  wire [6:0]        alarmIn,
   output reg  [6:0]        alarmInLed,
   // Relays and indicators
   output reg               loadSwitchOn,
   output reg               genRelayClosed,
   output reg               genLed,
   output reg               lowBatRelayClosed,
   output reg               highBatRelayClosed,
   output reg               loadAlarmRelayClosed,
   output reg               bankFailRelayClosed,
   output reg               logicOkRelay,
   output reg               logicOkLed,
   // Serial link
   input  wire              rx232,
   output reg               tx232,
   input  wire              rs485In,
   output reg               rs485Out,
   output reg               rs485Oe
);

   localparam BS_IDLE  = 2'd0;
   localparam BS_STUCK = 2'd1;
   localparam BS_OPEN  = 2'd2;

   reg  [7:0]  ctrl;
   reg  [7:0]  delaySec;
   reg  [15:0] discLvl;
   reg  [15:0] reconnLvl;
   reg  [15:0] genLvl;
   reg  [15:0] absMax;
   reg  [15:0] boostMax;
   reg  [15:0] curLimit;
   reg  [7:0]  siteNum;
   reg  [31:0] tenthCnt;
   reg         tenth;
   reg         lowOff;
   reg         hiOff;
   reg         ocOff;
   reg         genRun;
   reg         lowAlarm;
   reg         highAlarm;
   reg         loadAlarm;
   reg         bankFail;
   reg  [7:0]  next_delay;
   wire [31:0] status;
   wire [11:0] delayT;
   wire [5:0]  cond;
   wire [5:0]  qual;
   wire [71:0] tgt;
   wire [16:0] bat17;

   // APB slave, zero wait states
   wire        access = psel & penable;
   wire        mapped = (paddr <= `REG_STATUS) && (paddr[1:0] == 2'b00);
   assign pready  = 1'b1;
   assign pslverr = access & ~mapped;

   always @* begin
      next_delay = pwdata[7:0];
      if (pwdata[7:0] < `DELAY_MIN) begin
         next_delay = `DELAY_MIN;
      end else if (pwdata[7:0] > `DELAY_MAX) begin
         next_delay = `DELAY_MAX;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl      <= 8'h00;
         delaySec  <= `RST_DELAY;
         discLvl   <= `RST_DISC;
         reconnLvl <= `RST_RECONN;
         genLvl    <= `RST_GENSTART;
         absMax    <= `RST_ABSMAX;
         boostMax  <= `RST_BOOSTMAX;
         curLimit  <= `RST_ILIMIT;
         siteNum   <= `RST_SITE;
      end else if (access && pwrite) begin
         if (paddr == `REG_CTRL) begin
            ctrl <= {6'h00, pwdata[1:0]};
         end else if (paddr == `REG_DELAY) begin
            delaySec <= next_delay;
         end else if (paddr == `REG_DISC) begin
            discLvl <= pwdata[15:0];
         end else if (paddr == `REG_RECONN) begin
            reconnLvl <= pwdata[15:0];
         end else if (paddr == `REG_GENSTART) begin
            genLvl <= pwdata[15:0];
         end else if (paddr == `REG_ABSMAX) begin
            absMax <= pwdata[15:0];
         end else if (paddr == `REG_BOOSTMAX) begin
            boostMax <= pwdata[15:0];
         end else if (paddr == `REG_ILIMIT) begin
            curLimit <= pwdata[15:0];
         end else if (paddr == `REG_SITE) begin
            siteNum <= pwdata[7:0];
         end
      end
   end

   assign status = {16'h0000, 1'b0, alarmInLed, 1'b0, ctrl[`CTRL_FAIL], bankFail, loadAlarm,
                    highAlarm, lowAlarm, genRun, loadSwitchOn};

   // Read data is captured in the setup cycle so it stands through the access phase
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable) begin
         if (paddr == `REG_CTRL) begin
            prdata <= {24'h000000, ctrl};
         end else if (paddr == `REG_DELAY) begin
            prdata <= {24'h000000, delaySec};
         end else if (paddr == `REG_DISC) begin
            prdata <= {16'h0000, discLvl};
         end else if (paddr == `REG_RECONN) begin
            prdata <= {16'h0000, reconnLvl};
         end else if (paddr == `REG_GENSTART) begin
            prdata <= {16'h0000, genLvl};
         end else if (paddr == `REG_ABSMAX) begin
            prdata <= {16'h0000, absMax};
         end else if (paddr == `REG_BOOSTMAX) begin
            prdata <= {16'h0000, boostMax};
         end else if (paddr == `REG_ILIMIT) begin
            prdata <= {16'h0000, curLimit};
         end else if (paddr == `REG_SITE) begin
            prdata <= {24'h000000, siteNum};
         end else if (paddr == `REG_STATUS) begin
            prdata <= status;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Tenth-second tick; all delays are counted in tenths
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         tenthCnt <= 32'h00000000;
         tenth    <= 1'b0;
      end else if (tenthCnt == TENTH_CYCLES - 1) begin
         tenthCnt <= 32'h00000000;
         tenth    <= 1'b1;
      end else begin
         tenthCnt <= tenthCnt + 32'h00000001;
         tenth    <= 1'b0;
      end
   end

   // Test mode A forces 2 s in place of the programmed delay
   assign delayT = ctrl[`CTRL_TESTA] ? `TESTA_TENTHS
                                     : delaySec * `TENTHS_PER_SEC;
   assign bat17  = {1'b0, batVolt};

   // 0 low disconnect, 1 low reconnect, 2 overcurrent, 3 overcurrent retry,
   // 4 generator start, 5 generator stop
   assign cond[0] = batVolt < discLvl;
   assign cond[1] = lowOff && (batVolt > reconnLvl);
   assign cond[2] = loadCur > curLimit;
   assign cond[3] = ocOff;
   assign cond[4] = batVolt <= genLvl;
   assign cond[5] = genRun && (bat17 > {1'b0, reconnLvl} + `V_TENTH);
   assign tgt = {delayT, delayT, delayT, `OC_TENTHS, delayT, delayT};

   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1) begin : qualGen
         reg [11:0] cnt;
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt <= 12'h000;
            end else if (!cond[g]) begin
               cnt <= 12'h000;
            end else if (tenth && (cnt < tgt[g*12 +: 12])) begin
               cnt <= cnt + 12'h001;
            end
         end
         assign qual[g] = cond[g] && (cnt >= tgt[g*12 +: 12]);
      end
   endgenerate

   // Load switch, generator and battery alarms
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         lowOff    <= 1'b0;
         hiOff     <= 1'b0;
         ocOff     <= 1'b0;
         genRun    <= 1'b0;
         lowAlarm  <= 1'b0;
         highAlarm <= 1'b0;
         loadAlarm <= 1'b0;
      end else begin
         if (qual[0]) begin
            lowOff <= 1'b1;
         end else if (qual[1]) begin
            lowOff <= 1'b0;
         end
         if (bat17 > {1'b0, absMax} + `V_HIDISC) begin
            hiOff <= 1'b1;
         end else if (batVolt < boostMax) begin
            hiOff <= 1'b0;
         end
         // Overcurrent retries after the programmed delay so a fault cannot latch forever
         if (qual[2]) begin
            ocOff <= 1'b1;
         end else if (qual[3]) begin
            ocOff <= 1'b0;
         end
         if (qual[4]) begin
            genRun <= 1'b1;
         end else if (qual[5]) begin
            genRun <= 1'b0;
         end
         if (bat17 < {1'b0, genLvl} - `V_TENTH) begin
            lowAlarm <= 1'b1;
         end else if (bat17 >= {1'b0, genLvl} + `V_TENTH) begin
            lowAlarm <= 1'b0;
         end
         if (bat17 > {1'b0, absMax} + `V_TENTH) begin
            highAlarm <= 1'b1;
         end else if (batVolt < boostMax) begin
            highAlarm <= 1'b0;
         end
         loadAlarm <= ((bat17 > {1'b0, loadVolt} + `V_LOADDROP) &&
                       (batVolt < `V_LOADLOWBAT)) ||
                      (loadVolt < `V_LOADOFF);
      end
   end

   // Relay outputs: closed contacts mean no alarm, so a cut cable reads as alarm
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         loadSwitchOn         <= 1'b0;
         genRelayClosed       <= 1'b1;
         genLed               <= 1'b0;
         lowBatRelayClosed    <= 1'b0;
         highBatRelayClosed   <= 1'b0;
         loadAlarmRelayClosed <= 1'b0;
         bankFailRelayClosed  <= 1'b0;
         logicOkRelay         <= 1'b0;
         logicOkLed           <= 1'b0;
         alarmInLed           <= 7'h00;
      end else begin
         loadSwitchOn         <= ~(lowOff | hiOff | ocOff);
         genRelayClosed       <= ~genRun;
         genLed               <= genRun;
         lowBatRelayClosed    <= ~lowAlarm;
         highBatRelayClosed   <= ~highAlarm;
         loadAlarmRelayClosed <= ~loadAlarm;
         bankFailRelayClosed  <= ~bankFail;
         logicOkRelay         <= ~ctrl[`CTRL_FAIL];
         logicOkLed           <= ~ctrl[`CTRL_FAIL];
         alarmInLed           <= alarmIn;
      end
   end

   // Solar bank failure test
   reg [1:0]  bState;
   reg [13:0] periodCnt;
   reg [3:0]  settle;
   reg [1:0]  bankIdx;
   reg        bigCharge;
   reg        failAcc;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bState    <= BS_IDLE;
         periodCnt <= 14'h0000;
         settle    <= 4'h0;
         bankIdx   <= 2'd0;
         bigCharge <= 1'b0;
         failAcc   <= 1'b0;
         bankFail  <= 1'b0;
         bankOn    <= {NBANK{1'b0}};
      end else begin
         case (bState)
            BS_IDLE: begin
               bankOn <= bankReq;
               if (tenth) begin
                  if (periodCnt == `BANK_PERIOD - 14'h0001) begin
                     periodCnt <= 14'h0000;
                     bigCharge <= chargeCur > `I_OPENTEST;
                     failAcc   <= 1'b0;
                     settle    <= 4'h0;
                     bankOn    <= {NBANK{1'b0}};
                     bState    <= BS_STUCK;
                  end else begin
                     periodCnt <= periodCnt + 14'h0001;
                  end
               end
            end
            BS_STUCK: begin
               if (tenth) begin
                  if (settle == `SETTLE_TENTHS - 4'h1) begin
                     settle <= 4'h0;
                     if (bigCharge) begin
                        failAcc <= chargeCur > `I_STUCK;
                        bankIdx <= 2'd0;
                        bankOn  <= {{(NBANK-1){1'b0}}, 1'b1};
                        bState  <= BS_OPEN;
                     end else begin
                        bankFail <= chargeCur > `I_STUCK;
                        bState   <= BS_IDLE;
                     end
                  end else begin
                     settle <= settle + 4'h1;
                  end
               end
            end
            BS_OPEN: begin
               if (tenth) begin
                  if (settle == `SETTLE_TENTHS - 4'h1) begin
                     settle <= 4'h0;
                     if (bankIdx == NBANK - 1) begin
                        bankFail <= failAcc | (chargeCur <= `I_BANKMIN);
                        bState   <= BS_IDLE;
                     end else begin
                        failAcc <= failAcc | (chargeCur <= `I_BANKMIN);
                        bankIdx <= bankIdx + 2'd1;
                        bankOn  <= {NBANK{1'b0}} | ({{(NBANK-1){1'b0}}, 1'b1} << (bankIdx + 2'd1));
                     end
                  end else begin
                     settle <= settle + 4'h1;
                  end
               end
            end
            default: begin
               bState <= BS_IDLE;
            end
         endcase
      end
   end

   // Serial link: 8N1 receiver and transmitter
   wire        rxd = rx232 | rs485In;
   reg  [15:0] rxDiv;
   reg  [3:0]  rxBit;
   reg  [7:0]  rxShift;
   reg         rxBusy;
   reg         rxDone;
   reg         addrPhase;
   reg         matched;
   reg  [15:0] txDiv;
   reg  [3:0]  txBit;
   reg  [9:0]  txShift;
   reg         txBusy;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rxDiv   <= 16'h0000;
         rxBit   <= 4'h0;
         rxShift <= 8'h00;
         rxBusy  <= 1'b0;
         rxDone  <= 1'b0;
      end else begin
         rxDone <= 1'b0;
         if (!rxBusy) begin
            if (!rxd) begin
               rxBusy <= 1'b1;
               rxBit  <= 4'h0;
               rxDiv  <= BAUD_DIV[15:0] >> 1;
            end
         end else if (rxDiv != 16'h0000) begin
            rxDiv <= rxDiv - 16'h0001;
         end else begin
            rxDiv <= BAUD_DIV[15:0] - 16'h0001;
            rxBit <= rxBit + 4'h1;
            if (rxBit == 4'h0) begin
               rxBusy <= ~rxd;
            end else if (rxBit == 4'h9) begin
               rxBusy <= 1'b0;
               rxDone <= rxd;
            end else begin
               rxShift <= {rxd, rxShift[7:1]};
            end
         end
      end
   end

   // A query is a site byte then a code byte; only a matching site is answered
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         addrPhase <= 1'b1;
         matched   <= 1'b0;
         txDiv     <= 16'h0000;
         txBit     <= 4'h0;
         txShift   <= 10'h3ff;
         txBusy    <= 1'b0;
         tx232     <= 1'b1;
         rs485Out  <= 1'b1;
         rs485Oe   <= 1'b0;
      end else begin
         if (rxDone) begin
            addrPhase <= ~addrPhase;
            if (addrPhase) begin
               matched <= rxShift == siteNum;
            end else if (matched && !txBusy) begin
               txBusy  <= 1'b1;
               txBit   <= 4'h0;
               txDiv   <= BAUD_DIV[15:0] - 16'h0001;
               txShift <= (rxShift == `QRY_INPUTS) ? {1'b1, 1'b0, alarmInLed, 1'b0}
                          : {1'b1, 1'b0, ctrl[`CTRL_FAIL], bankFail, loadAlarm, genRun,
                             highAlarm, lowAlarm, ~loadSwitchOn, 1'b0};
            end
         end
         if (txBusy) begin
            if (txDiv != 16'h0000) begin
               txDiv <= txDiv - 16'h0001;
            end else begin
               txDiv   <= BAUD_DIV[15:0] - 16'h0001;
               txShift <= {1'b1, txShift[9:1]};
               txBit   <= txBit + 4'h1;
               if (txBit == 4'h9) begin
                  txBusy <= 1'b0;
               end
            end
         end
         tx232    <= txBusy ? txShift[0] : 1'b1;
         rs485Out <= txBusy ? txShift[0] : 1'b1;
         rs485Oe  <= txBusy;
      end
   end

endmodule // battery_load_alarm_supervisor

/* sim/supervisor_checker_asserts.sv */
`timescale 1ns/1ps
`include "supervisor_consts.vh"
module supervisor_checker (
   // Clock and reset
   input wire        clk,
   input wire        rst,
   // Measurements and contacts
   input wire [15:0] batVolt,
   input wire [15:0] loadVolt,
   input wire [6:0]  alarmIn,
   input wire [6:0]  alarmInLed,
   // Relays and indicators
   input wire        loadSwitchOn,
   input wire        genRelayClosed,
   input wire        loadAlarmRelayClosed,
   input wire        logicOkRelay,
   input wire        logicOkLed,
   // Serial link
   input wire        tx232,
   input wire        rs485Out,
   input wire        rs485Oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   led_copy_a: assert property ($stable(alarmIn)[*2] |-> alarmInLed == alarmIn)
      else $error("alarm lamps differ from contacts");
   tx_pair_a: assert property (tx232 == rs485Out)
      else $error("serial outputs differ");
   idle_high_a: assert property (!rs485Oe |-> tx232)
      else $error("transmit not idle while silent");
   ok_pair_a: assert property (logicOkRelay == logicOkLed)
      else $error("health relay and lamp disagree");
   load_off_a: assert property ((loadVolt < `V_LOADOFF)[*4] |-> !loadAlarmRelayClosed)
      else $error("dead load rail gives no alarm");
   sag_alarm_a: assert property ((batVolt < `V_LOADLOWBAT &&
      loadVolt + `V_LOADDROP < batVolt)[*4] |-> !loadAlarmRelayClosed)
      else $error("load sag gives no alarm");
   reply_start_a: assert property ($rose(rs485Oe) |-> ##[0:2] !tx232)
      else $error("reply lacks start bit");
   reply_hold_a: assert property ($rose(rs485Oe) |-> rs485Oe[*8])
      else $error("driver enable dropped early");

   cover property ($rose(rs485Oe));
   cover property ($fell(loadSwitchOn));
   cover property ($fell(genRelayClosed));
endmodule // supervisor_checker

/* sim/plant_model.sv */
`timescale 1ns/1ps
module plant_model #(
   parameter BAUD_DIV = 16
) (
   // Clock
   input  wire        clk,
   // Levels set by the bench
   input  wire [15:0] batLevel,
   input  wire [15:0] sag,
   // Device side
   input  wire        loadSwitchOn,
   input  wire        tx232,
   output wire [15:0] batVolt,
   output wire [15:0] loadVolt,
   output reg         rx232,
   output reg         rs485In
);
   assign batVolt  = batLevel;
   // An open switch lets the load rail fall to zero
   assign loadVolt = loadSwitchOn ? batLevel - sag : 16'h0000;

   initial begin
      rx232   = 1'b1;
      rs485In = 1'b0;
   end

   task send(input logic [7:0] b, input bit p, input int stop);
      int   i;
      logic v;
      for (i = 0; i < 10; i++) begin
         v = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
         // Paths are ORed, so the unused port rests low
         rx232   <= p ? 1'b0 : v;
         rs485In <= p ? v : 1'b0;
         repeat ((i == 9) ? stop : BAUD_DIV) @(posedge clk);
      end
   endtask

   // Every exchange opens with a site byte
   task query(input logic [7:0] s, input logic [7:0] c, input bit p);
      send(s, p, BAUD_DIV);
      send(c, p, 6);
   endtask

   task get(output logic [7:0] b, output bit got);
      int i;
      got = 1'b0;
      b = 8'h00;
      for (i = 0; i < 400 && !got; i++) begin
         @(posedge clk);
         got = !tx232;
      end
      if (got) begin
         repeat (BAUD_DIV / 2) @(posedge clk);
         for (i = 0; i < 8; i++) begin
            repeat (BAUD_DIV) @(posedge clk);
            b[i] = tx232;
         end
         repeat (2 * BAUD_DIV) @(posedge clk);
      end
   endtask
endmodule // plant_model

/* sim/test_battery_load_alarm_supervisor.sv */
`timescale 1ns/1ps
`include "supervisor_consts.vh"
module test_battery_load_alarm_supervisor;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, got;
   logic [7:0]  paddr, b;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] batVolt, loadVolt, loadCur, chargeCur, batLevel, sag;
   logic [3:0]  bankReq, bankOn;
   logic [6:0]  alarmIn, alarmInLed;
   logic        loadSwitchOn, genRelayClosed, genLed, lowBatRelayClosed, highBatRelayClosed;
   logic        loadAlarmRelayClosed, bankFailRelayClosed, logicOkRelay, logicOkLed;
   logic        tx232, rs485Out, rs485Oe, rx232, rs485In, err;
   int          bad_count, checks;

   battery_load_alarm_supervisor #(.TENTH_CYCLES(10), .BAUD_DIV(16), .NBANK(4))
   battery_load_alarm_supervisor_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .batVolt(batVolt), .loadVolt(loadVolt), .loadCur(loadCur),
      .chargeCur(chargeCur), .bankReq(bankReq), .bankOn(bankOn), .alarmIn(alarmIn),
      .alarmInLed(alarmInLed), .loadSwitchOn(loadSwitchOn), .genRelayClosed(genRelayClosed),
      .genLed(genLed), .lowBatRelayClosed(lowBatRelayClosed),
      .highBatRelayClosed(highBatRelayClosed), .loadAlarmRelayClosed(loadAlarmRelayClosed),
      .bankFailRelayClosed(bankFailRelayClosed), .logicOkRelay(logicOkRelay),
      .logicOkLed(logicOkLed), .rx232(rx232), .tx232(tx232), .rs485In(rs485In),
      .rs485Out(rs485Out), .rs485Oe(rs485Oe));

   plant_model #(.BAUD_DIV(16)) plant_model_inst (.clk(clk), .batLevel(batLevel), .sag(sag),
      .loadSwitchOn(loadSwitchOn), .tx232(tx232), .batVolt(batVolt), .loadVolt(loadVolt),
      .rx232(rx232), .rs485In(rs485In));

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task conclude;
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task t_regs;
      cyc(3);
      chk({lowBatRelayClosed, highBatRelayClosed, loadAlarmRelayClosed}, 32'h7);
      chk(bankFailRelayClosed, 32'h1);
      chk(bankOn, 32'ha);
      chk({logicOkRelay, logicOkLed}, 32'h3);
      bankReq <= 4'h6;
      apb(1'b0, `REG_DELAY, 32'h0);
      chk(rd, `RST_DELAY);
      chk(bankOn, 32'h6);
      apb(1'b0, 8'h28, 32'h0);
      chk(err, 32'h1);
      chk(rd, 32'h0);
      apb(1'b1, `REG_DELAY, 32'h0);
      apb(1'b0, `REG_DELAY, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, `REG_DELAY, 32'hff);
      apb(1'b0, `REG_DELAY, 32'h0);
      chk(rd, 32'hfa);
      apb(1'b1, `REG_DELAY, 32'h1);
      $display("register test done");
   endtask

   task t_low;
      batLevel <= 16'h044c;
      cyc(60);
      batLevel <= 16'h04b0;
      cyc(20);
      batLevel <= 16'h044c;
      cyc(80);
      chk(loadSwitchOn, 32'h1);
      chk(lowBatRelayClosed, 32'h0);
      cyc(40);
      chk(loadSwitchOn, 32'h0);
      chk({genRelayClosed, genLed}, 32'h1);
      chk(loadAlarmRelayClosed, 32'h0);
      batLevel <= 16'h0546;
      cyc(80);
      chk(loadSwitchOn, 32'h0);
      chk(lowBatRelayClosed, 32'h1);
      cyc(40);
      chk(loadSwitchOn, 32'h1);
      chk(genRelayClosed, 32'h1);
      $display("low battery test done");
   endtask

   task t_high;
      batLevel <= 16'h05eb;
      cyc(5);
      chk({loadSwitchOn, highBatRelayClosed}, 32'h2);
      batLevel <= 16'h05f5;
      cyc(5);
      chk(loadSwitchOn, 32'h0);
      batLevel <= 16'h05aa;
      cyc(5);
      chk({loadSwitchOn, highBatRelayClosed}, 32'h0);
      batLevel <= 16'h0596;
      cyc(5);
      chk({loadSwitchOn, highBatRelayClosed}, 32'h3);
      batLevel <= 16'h0546;
      loadCur <= 16'h13ec;
      cyc(18);
      chk(loadSwitchOn, 32'h1);
      cyc(22);
      chk(loadSwitchOn, 32'h0);
      loadCur <= 16'h0000;
      batLevel <= 16'h04d8;
      cyc(120);
      chk(loadAlarmRelayClosed, 32'h1);
      sag <= 16'h003c;
      cyc(6);
      chk(loadAlarmRelayClosed, 32'h0);
      sag <= 16'h0028;
      batLevel <= 16'h0546;
      $display("high battery test done");
   endtask

   task t_fast;
      apb(1'b1, `REG_CTRL, 32'h1);
      apb(1'b1, `REG_DELAY, 32'hfa);
      batLevel <= 16'h044c;
      cyc(150);
      chk(loadSwitchOn, 32'h1);
      cyc(80);
      chk(loadSwitchOn, 32'h0);
      batLevel <= 16'h0546;
      cyc(230);
      chk(loadSwitchOn, 32'h1);
      apb(1'b1, `REG_CTRL, 32'h0);
      apb(1'b1, `REG_DELAY, 32'h1);
      $display("test mode done");
   endtask

   task t_serial;
      alarmIn <= 7'h55;
      apb(1'b1, `REG_CTRL, 32'h2);
      cyc(3);
      chk(alarmInLed, 32'h55);
      chk({logicOkRelay, logicOkLed}, 32'h0);
      plant_model_inst.query(8'h01, `QRY_INPUTS, 1'b0);
      plant_model_inst.get(b, got);
      chk({got, b}, 32'h155);
      plant_model_inst.query(8'h02, `QRY_INPUTS, 1'b1);
      plant_model_inst.get(b, got);
      chk(got, 32'h0);
      plant_model_inst.query(8'h01, 8'h01, 1'b1);
      plant_model_inst.get(b, got);
      chk({got, b}, 32'h140);
      apb(1'b1, `REG_CTRL, 32'h0);
      $display("serial test done");
   endtask

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      #100000;
      bad_count++;
      conclude;
   end

   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      {loadCur, batLevel, sag, alarmIn} = {16'h0000, 16'h0546, 16'h0028, 7'h00};
      chargeCur = 16'h0000;
      bankReq = 4'ha;
      bad_count = 0;
      checks = 0;
      cyc(12);
      rst <= 1'b0;
      cyc(1);
      t_regs;
      t_low;
      t_high;
      t_fast;
      t_serial;
      conclude;
   end
endmodule // test_battery_load_alarm_supervisor

bind battery_load_alarm_supervisor supervisor_checker chk_inst (.clk(clk), .rst(rst),
   .batVolt(batVolt), .loadVolt(loadVolt), .alarmIn(alarmIn), .alarmInLed(alarmInLed),
   .loadSwitchOn(loadSwitchOn), .genRelayClosed(genRelayClosed),
   .loadAlarmRelayClosed(loadAlarmRelayClosed), .logicOkRelay(logicOkRelay),
   .logicOkLed(logicOkLed), .tx232(tx232), .rs485Out(rs485Out), .rs485Oe(rs485Oe));
